// *** ee_seq_pkg.sv ***
// Package for the data EEPROM erase/program sequencer.
// Assumes a 20 MHz system clock and a 16-bit register write port.
package ee_seq_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned CYCLE_TIME_US = 2000;
  localparam int unsigned CYCLE_CLKS    = CYCLE_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned LATCH_COUNT   = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 24;

  // Register select codes on the write port.
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_KEY     = 2'h1;
  localparam logic [1:0] SEL_ADDR_LO = 2'h2;
  localparam logic [1:0] SEL_ADDR_HI = 2'h3;

  // Control register fields.
  localparam int unsigned CTL_START_BIT  = 15;
  localparam int unsigned CTL_PERMIT_BIT = 14;
  localparam int unsigned CTL_OP_LSB     = 0;
  localparam int unsigned CTL_OP_W       = 7;
  localparam logic [15:0] CTL_RESET      = 16'h0000;

  localparam logic [6:0] OP_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OP_WORD_ERASE  = 7'h44;
  localparam logic [6:0] OP_WORD_PROG   = 7'h04;
  localparam logic [6:0] OP_BLOCK_PROG  = 7'h05;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_ARMED
  } key_state_t;
endpackage

// *** ee_cycle_timer.sv ***
// Counts out one erase or program cycle.
// Assumes start is a single-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none
module ee_cycle_timer #(
  parameter int unsigned CYCLES = 40000
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
    logic        done;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (s_q.busy) begin
      if (s_q.cnt == 32'h0000_0001) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      s_d.cnt = s_q.cnt - 32'h0000_0001;
    end else if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 32'(CYCLES);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
endmodule // ee_cycle_timer
`default_nettype wire

// *** ee_write_latches.sv ***
// Write latch bank filled by table writes, read by the program engine.
// Assumes one table write strobe per instruction.
`timescale 1ns/1ps
`default_nettype none
module ee_write_latches #(
  parameter int unsigned DEPTH  = 16,
  parameter int unsigned DATA_W = 16
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     wr,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [DATA_W-1:0]        wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [DATA_W-1:0]        rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
  } lat_state_t;

  lat_state_t s_q;
  lat_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.mem[rd_idx];
endmodule // ee_write_latches
`default_nettype wire

// *** ee_seq.sv ***
// Data EEPROM erase/program sequencer with unlock key and write permit.
// Assumes a CPU write port (sel, data, strobe) and a table-write strobe.
`timescale 1ns/1ps
`default_nettype none
module ee_seq
  import ee_seq_pkg::*;
#(
  parameter int unsigned CYCLE_LEN = ee_seq_pkg::CYCLE_CLKS,
  parameter int unsigned LATCHES   = ee_seq_pkg::LATCH_COUNT
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            reg_wr,
  input  wire logic [1:0]                      reg_sel,
  input  wire logic [ee_seq_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                            done_clr,
  input  wire logic                            table_write_low,
  input  wire logic [ee_seq_pkg::ADDR_W-1:0]   table_addr,
  input  wire logic [ee_seq_pkg::DATA_W-1:0]   table_data,
  output logic      [ee_seq_pkg::DATA_W-1:0]   nvm_control,
  output logic      [ee_seq_pkg::ADDR_W-1:0]   nvm_address,
  output logic                                 nvm_done_flag,
  output logic                                 nvm_busy,
  output logic                                 array_erase,
  output logic                                 array_erase_block,
  output logic                                 array_prog,
  output logic      [ee_seq_pkg::ADDR_W-1:0]   array_addr,
  output logic      [ee_seq_pkg::DATA_W-1:0]   array_data,
  output logic                                 array_we
);
  import ee_seq_pkg::*;

  localparam int unsigned IDX_W = $clog2(LATCHES);

  typedef struct packed {
    logic [DATA_W-1:0] ctl;
    logic [ADDR_W-1:0] addr;
    key_state_t        key;
    logic              done;
    logic              busy;
    logic [6:0]        op;
    logic [IDX_W:0]    pidx;
    logic              erase;
    logic              erase_blk;
    logic              prog;
    logic [DATA_W-1:0] adata;
    logic              awe;
  } seq_state_t;

  seq_state_t s_q;
  seq_state_t s_d;

  logic              tmr_start;
  logic              tmr_busy;
  logic              tmr_done;
  logic [DATA_W-1:0] lat_rd;
  logic [IDX_W-1:0]  lat_idx;

  function automatic logic op_is_prog(input logic [6:0] op);
    return (op == OP_WORD_PROG) || (op == OP_BLOCK_PROG);
  endfunction

  function automatic logic op_is_block(input logic [6:0] op);
    return (op == OP_BLOCK_ERASE) || (op == OP_BLOCK_PROG);
  endfunction

  ee_write_latches #(
    .DEPTH  (LATCHES),
    .DATA_W (DATA_W)
  ) u_latches (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (table_write_low),
    .wr_idx  (table_addr[IDX_W:1]),
    .wr_data (table_data),
    .rd_idx  (lat_idx),
    .rd_data (lat_rd)
  );

  ee_cycle_timer #(
    .CYCLES (CYCLE_LEN)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (tmr_start),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  logic ctl_wr;
  logic start_req;
  logic go;

  always_comb begin
    ctl_wr    = reg_wr && (reg_sel == SEL_CONTROL);
    // Start needs the permit already held, not set by the same write.
    start_req = ctl_wr && reg_wdata[CTL_START_BIT]
                && !s_q.ctl[CTL_START_BIT]
                && s_q.ctl[CTL_PERMIT_BIT]
                && reg_wdata[CTL_PERMIT_BIT];
    go        = start_req && (s_q.key == KEY_ARMED) && !s_q.busy;
    tmr_start = go;
    // A word program sends the latch selected by address register bits [IDX_W:1].
    lat_idx   = op_is_block(s_q.op) ? s_q.pidx[IDX_W-1:0] : s_q.addr[IDX_W:1];
  end

  always_comb begin
    s_d       = s_q;
    s_d.awe   = 1'b0;
    s_d.erase = 1'b0;
    s_d.prog  = 1'b0;

    if (reg_wr) begin
      case (reg_sel)
        SEL_KEY: begin
          if (reg_wdata[7:0] == KEY_FIRST) begin
            s_d.key = KEY_GOT_FIRST;
          end else if (reg_wdata[7:0] == KEY_SECOND && s_q.key == KEY_GOT_FIRST) begin
            s_d.key = KEY_ARMED;
          end else begin
            s_d.key = KEY_IDLE;
          end
        end
        SEL_CONTROL: begin
          s_d.key = KEY_IDLE;
          // Software owns the permit and op fields; only hardware sets start.
          s_d.ctl[CTL_PERMIT_BIT] = reg_wdata[CTL_PERMIT_BIT];
          if (!s_q.busy) begin
            s_d.ctl[CTL_OP_LSB +: CTL_OP_W] = reg_wdata[CTL_OP_LSB +: CTL_OP_W];
          end
        end
        SEL_ADDR_LO: begin
          s_d.key = KEY_IDLE;
          if (!s_q.busy) begin
            s_d.addr[15:0] = reg_wdata;
          end
        end
        SEL_ADDR_HI: begin
          s_d.key = KEY_IDLE;
          if (!s_q.busy) begin
            s_d.addr[ADDR_W-1:16] = reg_wdata[ADDR_W-17:0];
          end
        end
        default: begin
          s_d.key = KEY_IDLE;
        end
      endcase
    end

    if (table_write_low && !s_q.busy) begin
      s_d.addr = table_addr;
    end

    if (go) begin
      s_d.ctl[CTL_START_BIT] = 1'b1;
      s_d.busy      = 1'b1;
      s_d.op        = s_q.ctl[CTL_OP_LSB +: CTL_OP_W];
      s_d.pidx      = '0;
      s_d.erase     = !op_is_prog(s_q.ctl[CTL_OP_LSB +: CTL_OP_W]);
      s_d.erase_blk = op_is_block(s_q.ctl[CTL_OP_LSB +: CTL_OP_W]);
      s_d.prog      = op_is_prog(s_q.ctl[CTL_OP_LSB +: CTL_OP_W]);
    end

    // Block program data walks the latches while the timer runs, word program sends one; the CPU is free.
    if (s_q.busy && op_is_prog(s_q.op)) begin
      if (op_is_block(s_q.op) ? (s_q.pidx < (IDX_W+1)'(LATCHES))
                              : (s_q.pidx == '0)) begin
        s_d.awe   = 1'b1;
        s_d.adata = lat_rd;
        s_d.pidx  = s_q.pidx + (IDX_W+1)'(1);
      end
    end

    if (tmr_done) begin
      s_d.ctl[CTL_START_BIT] = 1'b0;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
    end else if (done_clr) begin
      s_d.done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q      <= '0;
      s_q.ctl  <= CTL_RESET;
      s_q.key  <= KEY_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign nvm_control       = s_q.ctl;
  assign nvm_address       = s_q.addr;
  assign nvm_done_flag     = s_q.done;
  assign nvm_busy          = s_q.busy;
  assign array_erase       = s_q.erase;
  assign array_erase_block = s_q.erase_blk;
  assign array_prog        = s_q.prog;
  assign array_addr        = s_q.addr;
  assign array_data        = s_q.adata;
  assign array_we          = s_q.awe;
endmodule // ee_seq
`default_nettype wire

// *** ee_seq_checker.sv ***
// Assertions on the ports of the EEPROM sequencer.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ee_seq_checker
  import ee_seq_pkg::*;
#(
  parameter int unsigned CYCLE_LEN = 20,
  parameter int unsigned LATCHES   = 16
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic [1:0]  reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic        done_clr,
  input wire logic        table_write_low,
  input wire logic [23:0] table_addr,
  input wire logic [15:0] nvm_control,
  input wire logic [23:0] nvm_address,
  input wire logic        nvm_done_flag,
  input wire logic        nvm_busy,
  input wire logic        array_erase,
  input wire logic        array_prog,
  input wire logic        array_we
);
  logic        ctl_wr;
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  assign ctl_wr = reg_wr && reg_sel == SEL_CONTROL;
  always_comb begin
    busy_cnt_d = nvm_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence end_s;
    !nvm_busy && nvm_done_flag && !nvm_control[15];
  endsequence
  sequence kind_s;
    array_erase == nvm_control[6] && array_prog == !nvm_control[6];
  endsequence
  chk_start_cause: assert property ($rose(nvm_busy) |->
    $past(ctl_wr && reg_wdata[15] && nvm_control[14])) else $error("start without cause");
  chk_permit_hold: assert property (!ctl_wr |=> $stable(nvm_control[14]))
    else $error("permit changed by hardware");
  chk_cycle_len: assert property ($fell(nvm_busy) |-> busy_cnt_q == CYCLE_LEN + 1)
    else $error("cycle length wrong");
  chk_done_set: assert property ($fell(nvm_busy) |-> end_s)
    else $error("completion not flagged");
  chk_done_sticky: assert property (nvm_done_flag && !done_clr |=> nvm_done_flag)
    else $error("done flag dropped");
  chk_op_kind: assert property ($rose(nvm_busy) |-> kind_s)
    else $error("wrong array operation");
  chk_we_busy: assert property (array_we |-> nvm_busy)
    else $error("latch write outside cycle");
  chk_addr_cap: assert property (table_write_low && !nvm_busy |=>
    nvm_address == $past(table_addr)) else $error("address not captured");
endmodule // ee_seq_checker
bind ee_seq ee_seq_checker #(.CYCLE_LEN(CYCLE_LEN), .LATCHES(LATCHES)) u_chk (
  .sys_clk, .rst, .reg_wr, .reg_sel, .reg_wdata, .done_clr, .table_write_low,
  .table_addr, .nvm_control, .nvm_address, .nvm_done_flag, .nvm_busy,
  .array_erase, .array_prog, .array_we);
`default_nettype wire

// *** ee_seq_bench.sv ***
// Self-checking bench for the EEPROM sequencer.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ee_seq_bench;
  import ee_seq_pkg::*;
  localparam int unsigned LEN = 20;
  logic        sys_clk, rst, reg_wr, done_clr, table_write_low;
  logic [1:0]  reg_sel;
  logic [15:0] reg_wdata, table_data, nvm_control, array_data, we_data;
  logic [23:0] table_addr, nvm_address, array_addr;
  logic        nvm_done_flag, nvm_busy, array_erase, array_erase_block;
  logic        array_prog, array_we;
  int          mismatches, cmp_count, we_n, k;
  ee_seq #(.CYCLE_LEN(LEN), .LATCHES(16)) dut (.sys_clk, .rst, .reg_wr,
    .reg_sel, .reg_wdata, .done_clr, .table_write_low, .table_addr,
    .table_data, .nvm_control, .nvm_address, .nvm_done_flag, .nvm_busy,
    .array_erase, .array_erase_block, .array_prog, .array_addr, .array_data,
    .array_we);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (array_we === 1'b1) begin
      we_n    <= we_n + 1;
      we_data <= array_data;
    end
  end
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic tw(input logic [23:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    table_write_low = 1'b1;
    table_addr = a;
    table_data = d;
    @(negedge sys_clk);
    table_write_low = 1'b0;
  endtask
  task automatic go(input logic [15:0] c);
    wr(SEL_KEY, 16'h0055);
    wr(SEL_KEY, 16'h00AA);
    wr(SEL_CONTROL, c);
  endtask
  task automatic run(input logic [15:0] op, input int n_we);
    int i;
    wr(SEL_CONTROL, 16'h4000 | op);
    we_n = 0;
    go(16'hC000 | op);
    chk("busy", 24'h1, {23'h0, nvm_busy});
    chk("erase", {23'h0, op[6]}, {23'h0, array_erase});
    chk("prog", {23'h0, !op[6]}, {23'h0, array_prog});
    chk("blk", {23'h0, op[0]}, {23'h0, array_erase_block});
    wr(SEL_CONTROL, op & 16'hBFFF);
    chk("permit", 24'h0, {23'h0, nvm_control[14]});
    for (i = 0; i < 100 && nvm_done_flag !== 1'b1; i++) @(negedge sys_clk);
    if (i == 100) begin
      mismatches++;
      end_sim();
    end
    chk("len", 24'(LEN - 1), i[23:0]);
    chk("start", 24'h0, {23'h0, nvm_control[15]});
    chk("we", n_we[23:0], we_n[23:0]);
    repeat (5) @(negedge sys_clk);
    chk("sticky", 24'h1, {23'h0, nvm_done_flag});
    done_clr = 1'b1;
    @(negedge sys_clk);
    done_clr = 1'b0;
    chk("clr", 24'h0, {23'h0, nvm_done_flag});
    $display("Cycle test %h done", op);
  endtask
  task automatic idle_chk();
    chk("ctl", 24'h0, {8'h0, nvm_control});
    chk("flags", 24'h0, {22'h0, nvm_busy, nvm_done_flag});
  endtask
  initial begin
    {rst, reg_wr, done_clr, table_write_low, reg_sel} = 6'h20;
    {reg_wdata, table_data, table_addr} = 56'h0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    idle_chk();
    go(16'hC044);
    chk("same", 24'h0, {23'h0, nvm_busy});
    wr(SEL_CONTROL, 16'h4044);
    wr(SEL_KEY, 16'h00AA);
    wr(SEL_KEY, 16'h0055);
    wr(SEL_CONTROL, 16'hC044);
    chk("order", 24'h0, {23'h0, nvm_busy});
    wr(SEL_KEY, 16'h0055);
    wr(SEL_ADDR_LO, 16'h0010);
    wr(SEL_KEY, 16'h00AA);
    wr(SEL_CONTROL, 16'hC044);
    chk("gap", 24'h0, {23'h0, nvm_busy});
    go(16'h4044);
    wr(SEL_CONTROL, 16'hC044);
    chk("used", 24'h0, {23'h0, nvm_busy});
    $display("Refusal test done");
    run(16'h4045, 0);
    run(16'h4044, 0);
    tw(24'h7FF012, 16'hBEEF);
    chk("addr", 24'h7FF012, nvm_address);
    chk("aaddr", 24'h7FF012, array_addr);
    run(16'h4004, 1);
    chk("data", 24'h00BEEF, {8'h0, we_data});
    for (k = 0; k < 16; k++) tw(24'h7FF000 + 24'(2 * k), 16'hA500 + 16'(k));
    chk("last", 24'h7FF01E, nvm_address);
    run(16'h4005, 16);
    chk("bdata", 24'h00A50F, {8'h0, we_data});
    wr(SEL_CONTROL, 16'h4044);
    go(16'hC044);
    rst = 1'b1;
    @(negedge sys_clk);
    idle_chk();
    rst = 1'b0;
    $display("Reset test done");
    end_sim();
  end
endmodule // ee_seq_bench
`default_nettype wire
